/* File: core/conv_clk_div.sv */
// Converter clock enable divider from the prescale bits
`timescale 1ns/100ps
module conv_clk_div (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic [3:0] div_sel,
  output logic            tick
);
  logic [3:0] cnt_ff;
  logic [3:0] last;

  // Highest set bit picks the divide ratio; zero means system clock
  function automatic logic [3:0] div_last(input logic [3:0] s);
    if (s[3]) return 4'hf;
    else if (s[2]) return 4'h7;
    else if (s[1]) return 4'h3;
    else if (s[0]) return 4'h1;
    else return 4'h0;
  endfunction

  assign last = div_last(div_sel);
  assign tick = run && (cnt_ff == last);

  // Counter restarts whenever the converter phase is not running
  always_ff @(posedge clk) begin
    if (reset || !run || tick) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
endmodule

/* File: core/sar_adc_ctrl.sv */
// Conversion sequencer and register file of the successive-approximation converter
`timescale 1ns/100ps
`include "sar_adc_regs.svh"
// What this block does
// RULE1 - Start by software bit or PWM trigger
// RULE2 - Busy bit reads conversion state; write zero ignored
// RULE3 - Software checks busy; restart aborts conversion
// RULE4 - Phases run sample, settle, convert in order
// RULE5 - Sampling length programmable, at least one microsecond; the six-bit field reaches at most 63 clocks (630 ns), timing_short flags it
// RULE6 - Settling length programmable, at least half microsecond; the five-bit field reaches at most 31 clocks (310 ns), timing_short flags it
// RULE7 - Conversion lasts thirteen converter clock cycles
// RULE8 - Ten-bit result, saturating at both ends
// RULE9 - Completion raises an interrupt request
// RULE10 - Disabling keeps a pending request
// RULE11 - Timer count captured when sampling ends
// RULE12 - Reference enable bit switches internal buffer
// RULE13 - Enable bit powers converter up or down
// RULE14 - Channel field routes selected analog input
// RULE15 - Software writes zero to reserved bits
// RULE16 - Result held until next conversion completes
// RULE17 - High byte read latches low bits
// RULE18 - Settling lasts programmed system clock periods
// RULE19 - Sampling lasts programmed system clock periods
// RULE20 - Completion clears busy, loads result, raises request
module sar_adc_ctrl
  import sar_adc_pkg::*;
#(
  parameter int TIMER_W  = 16,
  parameter int SAMPLE_W = 6,
  parameter int SETTLE_W = 5
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire bus_req_t           bus,
  output logic [7:0]              rdata,
  input  wire logic               pwm_trigger,
  input  wire logic [TIMER_W-1:0] timer_count,
  input  wire logic               comp_in,
  input  wire logic               irq_ack,
  output analog_ctl_t             analog,
  output logic                    busy,
  output logic                    irq_pending,
  output logic                    timing_short
);
  phase_t                phase_ff;
  ctrl_t                 ctrl_ff;
  logic [SAMPLE_W-1:0]   sample_ff;
  logic [SETTLE_W-1:0]   settle_ff;
  logic [3:0]            prescale_ff;
  logic [TIMER_W-1:0]    tcap_ff;
  logic [9:0]            result_ff;
  logic [1:0]            low_latch_ff;
  logic [7:0]            rdata_ff;
  logic                  irq_ff;
  logic [7:0]            phase_cnt_ff;
  logic [3:0]            conv_cnt_ff;
  logic [7:0]            conv_len_ff;
  logic [7:0]            nxt_rdata;
  logic [7:0]            sample_len;
  logic [7:0]            settle_len;
  logic [9:0]            sar_code;
  logic                  wr_ctrl;
  logic                  start_req;
  logic                  sample_end;
  logic                  settle_end;
  logic                  tick;
  logic                  done;
  logic                  sar_load;

  // Address match used by both the write and the read side
  function automatic logic hit(input logic [11:0] a, input logic [11:0] target);
    return a == target;
  endfunction

  assign wr_ctrl    = bus.wr && hit(bus.addr, `ADC_CTRL_ADDR);
  // Software start bit or PWM trigger, only while powered
  assign start_req  = ctrl_ff.converter_power_on &&
                      ((wr_ctrl && bus.wdata[`CTRL_START_BIT]) || pwm_trigger); // RULE1 RULE2
  // A zero count still gives one system clock of each phase
  assign sample_len = (sample_ff == '0) ? 8'h01 : 8'(sample_ff);
  assign settle_len = (settle_ff == '0) ? 8'h01 : 8'(settle_ff);
  assign sample_end = (phase_ff == PH_SAMPLE) && (phase_cnt_ff >= sample_len); // RULE19
  assign settle_end = (phase_ff == PH_SETTLE) && (phase_cnt_ff >= settle_len); // RULE18
  assign done       = (phase_ff == PH_CONVERT) && tick && (conv_cnt_ff == `CONV_LAST_TICK); // RULE7
  assign sar_load   = settle_end && !start_req;

  conv_clk_div u_div (
    .clk     (clk),
    .reset   (reset),
    .run     (phase_ff == PH_CONVERT),
    .div_sel (prescale_ff),
    .tick    (tick)
  );

  sar_register #(.BITS(10)) u_sar (
    .clk     (clk),
    .reset   (reset),
    .load    (sar_load),
    .decide  ((phase_ff == PH_CONVERT) && tick && (conv_cnt_ff < `SAR_DECIDE_TICKS)),
    .comp_in (comp_in),
    .code    (sar_code)
  );

  // Phase sequencer; a start while busy or a power-down aborts
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_ff <= PH_IDLE;
    end else if (!ctrl_ff.converter_power_on) begin
      phase_ff <= PH_IDLE; // RULE13
    end else if (start_req) begin
      phase_ff <= (phase_ff == PH_IDLE) ? PH_SAMPLE : PH_IDLE; // RULE3
    end else begin
      case (phase_ff)
        PH_SAMPLE:  if (sample_end) phase_ff <= PH_SETTLE; // RULE4
        PH_SETTLE:  if (settle_end) phase_ff <= PH_CONVERT; // RULE4
        PH_CONVERT: if (done) phase_ff <= PH_IDLE; // RULE20
        default:    phase_ff <= PH_IDLE;
      endcase
    end
  end

  // System clock count within the sample and settle phases
  always_ff @(posedge clk) begin
    if (reset || start_req || sample_end || phase_ff == PH_IDLE) begin
      phase_cnt_ff <= 8'h01;
    end else if (phase_cnt_ff != 8'hff) begin
      phase_cnt_ff <= phase_cnt_ff + 8'h01;
    end
  end

  // Converter clock count within the conversion phase
  always_ff @(posedge clk) begin
    if (reset || phase_ff != PH_CONVERT) begin
      conv_cnt_ff <= 4'h0;
    end else if (tick) begin
      conv_cnt_ff <= conv_cnt_ff + 4'h1;
    end
  end

  // Length of the running conversion phase in system clocks, used only by the checks
  always_ff @(posedge clk) begin
    if (reset || phase_ff != PH_CONVERT) begin
      conv_len_ff <= 8'h00;
    end else if (conv_len_ff != 8'hff) begin
      conv_len_ff <= conv_len_ff + 8'h01;
    end
  end

  // Control, timing and prescale registers
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_ff     <= `CTRL_RESET;
      settle_ff   <= `SETTLE_RESET;
      sample_ff   <= `SAMPLE_RESET;
      prescale_ff <= `PRESCALE_RESET;
    end else if (bus.wr) begin
      if (hit(bus.addr, `ADC_CTRL_ADDR)) begin
        ctrl_ff <= bus.wdata[6:0]; // RULE12 RULE13 RULE14
      end else if (hit(bus.addr, `ADC_SETTLE_ADDR)) begin
        settle_ff <= bus.wdata[SETTLE_W-1:0]; // RULE6
      end else if (hit(bus.addr, `ADC_SAMPLE_ADDR)) begin
        sample_ff <= bus.wdata[SAMPLE_W-1:0]; // RULE5
      end else if (hit(bus.addr, `ADC_PRESCALE_ADDR)) begin
        prescale_ff <= bus.wdata[3:0];
      end
    end
  end

  // Timer snapshot as sampling ends
  always_ff @(posedge clk) begin
    if (reset) begin
      tcap_ff <= '0;
    end else if (sample_end && !start_req && ctrl_ff.converter_power_on) begin
      tcap_ff <= timer_count; // RULE11
    end
  end

  // Result held until the next completion
  always_ff @(posedge clk) begin
    if (reset) begin
      result_ff <= '0;
    end else if (done && !start_req && ctrl_ff.converter_power_on) begin
      result_ff <= sar_code; // RULE16 RULE20
    end
  end

  // Reading the high byte freezes the matching low bits
  always_ff @(posedge clk) begin
    if (reset) begin
      low_latch_ff <= 2'h0;
    end else if (bus.rd && hit(bus.addr, `ADC_DATA_HI_ADDR)) begin
      low_latch_ff <= result_ff[1:0]; // RULE17
    end
  end

  // Pending request; a completion beats a same-cycle acknowledge, power-down leaves it
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_ff <= 1'b0;
    end else if (done && !start_req && ctrl_ff.converter_power_on) begin
      irq_ff <= 1'b1; // RULE9 RULE20
    end else if (irq_ack) begin
      irq_ff <= 1'b0; // RULE10
    end
  end

  // Read data mux; unmapped addresses read zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (hit(bus.addr, `ADC_CTRL_ADDR)) begin
      nxt_rdata = {busy, ctrl_ff}; // RULE2
    end else if (hit(bus.addr, `ADC_RAW_ADDR)) begin
      nxt_rdata = sar_code[9:2];
    end else if (hit(bus.addr, `ADC_DATA_HI_ADDR)) begin
      nxt_rdata = result_ff[9:2];
    end else if (hit(bus.addr, `ADC_DATA_LO_ADDR)) begin
      nxt_rdata = {low_latch_ff, 6'h00};
    end else if (hit(bus.addr, `ADC_SETTLE_ADDR)) begin
      nxt_rdata = 8'(settle_ff);
    end else if (hit(bus.addr, `ADC_SAMPLE_ADDR)) begin
      nxt_rdata = 8'(sample_ff);
    end else if (hit(bus.addr, `ADC_PRESCALE_ADDR)) begin
      nxt_rdata = {4'h0, prescale_ff};
    end else if (hit(bus.addr, `ADC_TCAP_HI_ADDR)) begin
      nxt_rdata = tcap_ff[TIMER_W-1 -: 8];
    end else if (hit(bus.addr, `ADC_TCAP_LO_ADDR)) begin
      nxt_rdata = tcap_ff[7:0];
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset || !bus.rd) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Outputs toward the analog front end and the system
  assign rdata                        = rdata_ff;
  assign busy                         = (phase_ff != PH_IDLE);
  assign irq_pending                  = irq_ff;
  assign timing_short                 = (sample_len < `SAMPLE_MIN_CYC) ||
                                        (settle_len < `SETTLE_MIN_CYC); // RULE5 RULE6
  assign analog.sample_hold           = (phase_ff == PH_SAMPLE);
  assign analog.sar_start             = (phase_ff == PH_CONVERT);
  assign analog.internal_reference_on = ctrl_ff.internal_reference_on; // RULE12
  assign analog.converter_power_on    = ctrl_ff.converter_power_on; // RULE13
  assign analog.input_channel_select  = ctrl_ff.input_channel_select; // RULE14
  assign analog.dac_code              = sar_code;

  // Checks
  property p_start_busy;
    @(posedge clk) disable iff (reset)
      (start_req && !busy) |=> busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start did not set busy"); // RULE1

  property p_write_zero;
    @(posedge clk) disable iff (reset)
      (wr_ctrl && !bus.wdata[`CTRL_START_BIT] && !pwm_trigger && !busy) |=> !busy;
  endproperty
  a_write_zero: assert property (p_write_zero) else $error("writing zero started"); // RULE2

  sequence s_leave_sample;
    (phase_ff == PH_SAMPLE) ##1 (phase_ff != PH_SAMPLE);
  endsequence
  property p_order;
    @(posedge clk) disable iff (reset)
      s_leave_sample |-> (phase_ff == PH_SETTLE || phase_ff == PH_IDLE);
  endproperty
  a_order: assert property (p_order) else $error("sample not followed by settle"); // RULE4

  property p_sample_len;
    @(posedge clk) disable iff (reset)
      ($rose(phase_ff == PH_SAMPLE) && sample_ff == 6'h03) |->
        (phase_ff == PH_SAMPLE)[*3] ##1 (phase_ff != PH_SAMPLE);
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sample length wrong"); // RULE19

  property p_settle_len;
    @(posedge clk) disable iff (reset || start_req || !ctrl_ff.converter_power_on)
      ($rose(phase_ff == PH_SETTLE) && settle_ff == 5'h02) |->
        (phase_ff == PH_SETTLE)[*2] ##1 (phase_ff == PH_CONVERT);
  endproperty
  a_settle_len: assert property (p_settle_len) else $error("settle length wrong"); // RULE18

  property p_conv13;
    @(posedge clk) disable iff (reset || start_req || !ctrl_ff.converter_power_on)
      (done && prescale_ff == 4'h0) |->
        (conv_len_ff == 8'h0c) ##1 (phase_ff == PH_IDLE);
  endproperty
  a_conv13: assert property (p_conv13) else $error("conversion not 13 ticks"); // RULE7

  // Divide by four: thirteen slow ticks are fifty-two system clocks
  property p_conv_div4;
    @(posedge clk) disable iff (reset || start_req || !ctrl_ff.converter_power_on)
      (done && prescale_ff == 4'h2) |-> (conv_len_ff == 8'h33);
  endproperty
  a_conv_div4: assert property (p_conv_div4) else $error("divided conversion length wrong"); // RULE7

  // A restart while busy drops to idle and completes nothing
  property p_abort;
    @(posedge clk) disable iff (reset)
      (start_req && busy) |=> (!busy && $stable(result_ff) && !$rose(irq_pending));
  endproperty
  a_abort: assert property (p_abort) else $error("restart did not abort"); // RULE3

  property p_capture;
    @(posedge clk) disable iff (reset)
      s_leave_sample ##0 (phase_ff == PH_SETTLE) |-> tcap_ff == $past(timer_count);
  endproperty
  a_capture: assert property (p_capture) else $error("timer not captured"); // RULE11

  property p_done;
    @(posedge clk) disable iff (reset)
      (done && !start_req && ctrl_ff.converter_power_on) |=>
        (!busy && irq_pending && result_ff == $past(sar_code));
  endproperty
  a_done: assert property (p_done) else $error("completion effects missing"); // RULE20

  property p_irq_hold;
    @(posedge clk) disable iff (reset)
      (irq_pending && !irq_ack) |=> irq_pending;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("pending request lost"); // RULE10

  property p_hold;
    @(posedge clk) disable iff (reset)
      !done |=> $stable(result_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed early"); // RULE16

  property p_latch;
    @(posedge clk) disable iff (reset)
      (bus.rd && hit(bus.addr, `ADC_DATA_HI_ADDR)) |=>
        (low_latch_ff == $past(result_ff[1:0]) && rdata == $past(result_ff[9:2]));
  endproperty
  a_latch: assert property (p_latch) else $error("low bits not latched"); // RULE17

  property p_power_off;
    @(posedge clk) disable iff (reset)
      !ctrl_ff.converter_power_on |=> !busy;
  endproperty
  a_power_off: assert property (p_power_off) else $error("busy while powered down"); // RULE13
endmodule

/* File: core/sar_adc_pkg.sv */
// Types shared by the converter control modules
package sar_adc_pkg;
  typedef enum logic [1:0] {PH_IDLE, PH_SAMPLE, PH_SETTLE, PH_CONVERT} phase_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;
  typedef struct packed {
    logic       rsv6;
    logic       internal_reference_on;
    logic       converter_power_on;
    logic       rsv3;
    logic [2:0] input_channel_select;
  } ctrl_t;
  typedef struct packed {
    logic       sample_hold;
    logic       sar_start;
    logic       internal_reference_on;
    logic       converter_power_on;
    logic [2:0] input_channel_select;
    logic [9:0] dac_code;
  } analog_ctl_t;
endpackage

/* File: core/sar_adc_regs.svh */
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH
`define ADC_CTRL_ADDR     12'hf70
`define ADC_RAW_ADDR      12'hf71
`define ADC_DATA_HI_ADDR  12'hf72
`define ADC_DATA_LO_ADDR  12'hf73
`define ADC_SETTLE_ADDR   12'hf74
`define ADC_SAMPLE_ADDR   12'hf75
`define ADC_PRESCALE_ADDR 12'hf76
`define ADC_TCAP_HI_ADDR  12'hf78
`define ADC_TCAP_LO_ADDR  12'hf79
`define CTRL_START_BIT    7
`define CTRL_RESET        7'h00
`define SETTLE_RESET      5'h1f
`define SAMPLE_RESET      6'h3f
`define PRESCALE_RESET    4'h0
`define CONV_LAST_TICK    4'hc
`define SAR_DECIDE_TICKS  4'ha
`define CLK_PERIOD_NS     10
`define SAMPLE_MIN_NS     1000
`define SETTLE_MIN_NS     500
`define SAMPLE_MIN_CYC    (8'((`SAMPLE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define SETTLE_MIN_CYC    (8'((`SETTLE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`endif

/* File: core/sar_register.sv */
// Successive-approximation trial register
`timescale 1ns/100ps
module sar_register #(
  parameter int BITS = 10
) (
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            load,
  input  wire logic            decide,
  input  wire logic            comp_in,
  output logic [BITS-1:0]      code
);
  localparam int IW = $clog2(BITS);
  logic [IW-1:0] bit_ff;

  // Trial from midscale; a low comparator drops the bit, out-of-range inputs saturate
  always_ff @(posedge clk) begin
    if (reset) begin
      code   <= '0;
      bit_ff <= '0;
    end else if (load) begin
      code   <= BITS'(1) << (BITS - 1);
      bit_ff <= IW'(BITS - 1);
    end else if (decide) begin
      if (!comp_in) begin
        code[bit_ff] <= 1'b0; // RULE8
      end
      if (bit_ff != '0) begin
        code[bit_ff - IW'(1)] <= 1'b1;
        bit_ff               <= bit_ff - IW'(1);
      end
    end
  end
endmodule

/* File: verif/analog_input_model.sv */
// Analog input multiplexer and comparator model at the converter's far side
`timescale 1ns/100ps
module analog_input_model
  import sar_adc_pkg::*;
(
  input  wire logic            clk,
  input  wire analog_ctl_t     analog,
  input  wire logic [7:0][9:0] levels,
  output logic                 comp_in
);
  logic [9:0] held_ff;
  logic       junk_ff = 1'b0;

  // Track the routed input while sampling, hold it once sampling ends
  always_ff @(posedge clk) begin
    junk_ff <= ~junk_ff;
    if (analog.sample_hold && analog.converter_power_on) begin
      held_ff <= levels[analog.input_channel_select];
    end
  end

  // Held input against the trial code; a toggling line outside conversion
  assign comp_in = analog.sar_start ? (held_ff >= analog.dac_code) : junk_ff;
endmodule

/* File: verif/test_sar_adc_conversion_control.sv */
// Self-checking bench for the converter control sequencer
`timescale 1ns/100ps
`include "sar_adc_regs.svh"
module test_sar_adc_conversion_control
  import sar_adc_pkg::*;
;
  logic            clk;
  logic            reset;
  bus_req_t        bus;
  logic [7:0]      rdata;
  logic            pwm_trigger;
  logic [15:0]     timer_count;
  logic            comp_in;
  logic            irq_ack;
  analog_ctl_t     analog;
  logic            busy;
  logic            irq_pending;
  logic            timing_short;
  logic [7:0][9:0] levels;
  logic [15:0]     tcap_seen;
  int              miscompares;
  int              num_checks;
  int              cycles;
  int              conv_div;

  sar_adc_ctrl i_dut (
    .clk          (clk),
    .reset        (reset),
    .bus          (bus),
    .rdata        (rdata),
    .pwm_trigger  (pwm_trigger),
    .timer_count  (timer_count),
    .comp_in      (comp_in),
    .irq_ack      (irq_ack),
    .analog       (analog),
    .busy         (busy),
    .irq_pending  (irq_pending),
    .timing_short (timing_short)
  );

  analog_input_model i_far (.clk(clk), .analog(analog), .levels(levels), .comp_in(comp_in));

  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Free-running timer, last timer value of sampling, and hang guard
  always @(posedge clk) begin
    timer_count <= timer_count + 16'h0001;
    if (analog.sample_hold) begin
      tcap_seen <= timer_count;
    end
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic check_reg(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    check($sformatf("reg %h", a), 16'(exp), 16'(rdata));
  endtask

  task automatic irq_clear();
    @(posedge clk);
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
    #1;
    check("irq after ack", 16'h0000, 16'(irq_pending));
  endtask

  // Start one conversion, count its phases, then judge result and capture
  task automatic run_conv(input logic [2:0] ch, input bit by_pwm, input int st, input int sst, input bit full);
    int n;
    int nsh;
    int ncv;
    n = 0;
    nsh = 0;
    ncv = 0;
    if (by_pwm) begin
      @(posedge clk);
      pwm_trigger <= 1'b1;
      @(posedge clk);
      pwm_trigger <= 1'b0;
    end else begin
      reg_write(`ADC_CTRL_ADDR, {5'b10010, ch});
    end
    #1;
    check("channel", 16'(ch), 16'(analog.input_channel_select));
    while (busy === 1'b1 && n < 300) begin
      nsh += int'(analog.sample_hold);
      ncv += int'(analog.sar_start);
      n++;
      @(posedge clk);
      #1;
    end
    check("busy cycles", 16'(st + sst + 13 * conv_div), 16'(n));
    check("sample cycles", 16'(st), 16'(nsh));
    check("convert cycles", 16'(13 * conv_div), 16'(ncv));
    check("irq at done", 16'h0001, 16'(irq_pending));
    check_reg(`ADC_TCAP_HI_ADDR, tcap_seen[15:8]);
    check_reg(`ADC_TCAP_LO_ADDR, tcap_seen[7:0]);
    if (full) begin
      check_reg(`ADC_DATA_HI_ADDR, levels[ch][9:2]);
      check_reg(`ADC_DATA_LO_ADDR, {levels[ch][1:0], 6'h00});
    end
  endtask

  task automatic test_reset_values();
    check_reg(`ADC_CTRL_ADDR, 8'h00);
    check_reg(`ADC_SETTLE_ADDR, 8'h1f);
    check_reg(`ADC_SAMPLE_ADDR, 8'h3f);
    check_reg(`ADC_PRESCALE_ADDR, 8'h00);
    check_reg(12'hf7f, 8'h00);
    // Six-bit sample field can never reach one microsecond at this clock
    check("timing short", 16'h0001, 16'(timing_short));
  endtask

  // Every channel, counts varied up to the field maxima
  task automatic test_channels();
    int st;
    int sst;
    // A start only counts once the converter is already powered
    reg_write(`ADC_CTRL_ADDR, 8'h10);
    for (int ch = 0; ch < 8; ch++) begin
      st = (ch == 7) ? 63 : ch + 1;
      sst = (ch == 7) ? 31 : 8 - ch;
      reg_write(`ADC_SAMPLE_ADDR, 8'(st));
      reg_write(`ADC_SETTLE_ADDR, 8'(sst));
      irq_clear();
      run_conv(3'(ch), 1'b0, st, sst, 1'b1);
    end
  endtask

  // PWM start; low bits follow only the high byte read
  task automatic test_pwm_and_latch();
    reg_write(`ADC_SAMPLE_ADDR, 8'h03);
    reg_write(`ADC_SETTLE_ADDR, 8'h02);
    reg_write(`ADC_CTRL_ADDR, 8'h17);
    #1;
    check("write zero start", 16'h0000, 16'(busy));
    irq_clear();
    run_conv(3'h7, 1'b1, 3, 2, 1'b1);
    reg_write(`ADC_CTRL_ADDR, 8'h10);
    irq_clear();
    run_conv(3'h0, 1'b1, 3, 2, 1'b0);
    check_reg(`ADC_DATA_LO_ADDR, 8'hc0);
    check_reg(`ADC_DATA_HI_ADDR, 8'h00);
    check_reg(`ADC_DATA_LO_ADDR, 8'h00);
  endtask

  // Divided converter clock stretches the conversion phase
  task automatic test_prescale();
    reg_write(`ADC_PRESCALE_ADDR, 8'h02);
    check_reg(`ADC_PRESCALE_ADDR, 8'h02);
    conv_div = 4;
    irq_clear();
    run_conv(3'h5, 1'b0, 3, 2, 1'b1);
    reg_write(`ADC_PRESCALE_ADDR, 8'h00);
    conv_div = 1;
  endtask

  // Restart while busy aborts; old result kept, no request
  task automatic test_abort();
    irq_clear();
    reg_write(`ADC_CTRL_ADDR, 8'h91);
    check_reg(`ADC_CTRL_ADDR, 8'h91);
    reg_write(`ADC_CTRL_ADDR, 8'h91);
    #1;
    check("busy after restart", 16'h0000, 16'(busy));
    repeat (40) @(posedge clk);
    #1;
    check("irq after abort", 16'h0000, 16'(irq_pending));
    check_reg(`ADC_DATA_HI_ADDR, 8'haa);
  endtask

  // Disable keeps a pending request; start while off ignored
  task automatic test_disable();
    run_conv(3'h2, 1'b0, 3, 2, 1'b1);
    reg_write(`ADC_CTRL_ADDR, 8'h92);
    reg_write(`ADC_CTRL_ADDR, 8'h02);
    // Power-down reaches the sequencer one clock after the write lands
    @(posedge clk);
    #1;
    check("busy after disable", 16'h0000, 16'(busy));
    check("irq kept", 16'h0001, 16'(irq_pending));
    check("power line", 16'h0000, 16'(analog.converter_power_on));
    reg_write(`ADC_CTRL_ADDR, 8'h80);
    #1;
    check("start while off", 16'h0000, 16'(busy));
    reg_write(`ADC_CTRL_ADDR, 8'h22);
    #1;
    check("reference line", 16'h0001, 16'(analog.internal_reference_on));
    check_reg(`ADC_CTRL_ADDR, 8'h22);
    reg_write(`ADC_CTRL_ADDR, 8'h12);
    #1;
    check("reference off", 16'h0000, 16'(analog.internal_reference_on));
  endtask

  // Main sequence
  initial begin
    reset = 1'b1;
    bus = '0;
    pwm_trigger = 1'b0;
    irq_ack = 1'b0;
    timer_count = 16'h1230;
    tcap_seen = 16'h0000;
    cycles = 0;
    conv_div = 1;
    miscompares = 0;
    num_checks = 0;
    levels = {10'h3ff, 10'h155, 10'h2aa, 10'h001, 10'h200, 10'h1ff, 10'h3fe, 10'h000};
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    test_reset_values();
    test_channels();
    test_pwm_and_latch();
    test_prescale();
    test_abort();
    test_disable();
    tally_and_finish();
  end
endmodule
